// ---- startup_seq_pkg.sv ----
// Constants and types shared by the startup and reset sequencer
// ----------------------------------------------------------------------------
// Summary of operation
// - Global reset held while external reset or power-on hold is active.
// - Startup follows external reset release or power-on hold expiry.
// - Power-on hold lasts typically 3 ms after core supply good.
// - Clock request variant raises its request about 120 us after reset.
// - Chip stays in sleep at least 4.2 ms after leaving reset.
// - Without external oscillator, crystal pins drive the oscillator.
// - No toggling on slow clock input selects internal slow oscillator.
// ----------------------------------------------------------------------------
package startup_seq_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned POR_HOLD_US    = 3000;
  localparam int unsigned POR_MIN_US     = 1500;
  localparam int unsigned CLKREQ_DLY_US  = 120;
  localparam int unsigned SLEEP_MIN_US   = 4200;
  localparam int unsigned SLOW_WDOG_US   = 100;
  localparam int unsigned PS_PER_US      = 1000000;

  // Least times use the same truncated cycles per us as typical ones, nothing rounds up
  localparam int unsigned POR_HOLD_CYC =
    (POR_HOLD_US * (PS_PER_US / CLK_PERIOD_PS));
  localparam int unsigned CLKREQ_DLY_CYC =
    (CLKREQ_DLY_US * (PS_PER_US / CLK_PERIOD_PS));
  localparam int unsigned SLEEP_MIN_CYC =
    (SLEEP_MIN_US * (PS_PER_US / CLK_PERIOD_PS));
  localparam int unsigned SLOW_WDOG_CYC =
    (SLOW_WDOG_US * (PS_PER_US / CLK_PERIOD_PS));

  localparam int unsigned CNT_W = 24;

  // --------------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_SLEEP = 2'b01,
    ST_RUN   = 2'b10
  } seq_state_t;

endpackage

// ---- startup_reset_sequencer.sv ----
// Startup and reset sequencer: reset merge, clock request, sleep, clock select
module startup_reset_sequencer
  import startup_seq_pkg::*;
#(
  parameter bit          HAS_CLK_REQ  = 1'b1,
  parameter int unsigned POR_CYC      = startup_seq_pkg::POR_HOLD_CYC,
  parameter int unsigned CLKREQ_CYC   = startup_seq_pkg::CLKREQ_DLY_CYC,
  parameter int unsigned SLEEP_CYC    = startup_seq_pkg::SLEEP_MIN_CYC,
  parameter int unsigned SLOW_WDG_CYC = startup_seq_pkg::SLOW_WDOG_CYC
) (
  // Clock and power-up reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Supply and external reset pins
  input  wire logic core_supply_good,
  input  wire logic ext_reset_n,
  // Clock sources
  input  wire logic tcxo_present,
  input  wire logic slow_clock_input,
  // Outputs
  output logic      global_reset_n,
  output logic      clk_request,
  output logic      crystal_osc_en,
  output logic      slow_oscillator_internal,
  output logic      startup_go,
  output startup_seq_pkg::seq_state_t seq_state
);
  import startup_seq_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       supply_s;
  logic       ext_rst_n_s;
  logic       tcxo_s;
  logic       slow_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {slow_clock_input, tcxo_present, ext_reset_n,
                  core_supply_good};
      sync2_q <= sync1_q;
    end
  end

  assign supply_s    = sync2_q[0];
  assign ext_rst_n_s = sync2_q[1];
  assign tcxo_s      = sync2_q[2];
  assign slow_s      = sync2_q[3];

  // --------------------------------------------------------------------------
  // Power-on hold
  // --------------------------------------------------------------------------
  // Restarts whenever the supply drops below its threshold
  logic [CNT_W-1:0] por_cnt_q;
  logic             por_active_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_q    <= '0;
      por_active_q <= 1'b1;
    end else if (!supply_s) begin
      por_cnt_q    <= '0;
      por_active_q <= 1'b1;
    end else if (por_active_q) begin
      if (por_cnt_q == CNT_W'(POR_CYC - 1)) begin
        por_active_q <= 1'b0;
      end else begin
        por_cnt_q <= por_cnt_q + CNT_W'(1);
      end
    end
  end

  // --------------------------------------------------------------------------
  // Global reset merge
  // --------------------------------------------------------------------------
  // Whichever source releases last ends the reset
  logic hold_reset;
  assign hold_reset = por_active_q | ~ext_rst_n_s;

  // --------------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------------
  seq_state_t       state_q;
  logic [CNT_W-1:0] seq_cnt_q;

  // Both triggers converge here: release of hold_reset starts the sleep
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_RESET;
      seq_cnt_q <= '0;
    end else if (hold_reset) begin
      state_q   <= ST_RESET;
      seq_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_RESET: begin
          state_q   <= ST_SLEEP;
          seq_cnt_q <= '0;
        end
        ST_SLEEP: begin
          if (seq_cnt_q == CNT_W'(SLEEP_CYC - 1)) begin
            state_q <= ST_RUN;
          end else begin
            seq_cnt_q <= seq_cnt_q + CNT_W'(1);
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Clock request
  // --------------------------------------------------------------------------
  // Timed from the sleep counter, so no extra counter is spent on it
  logic clk_req_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_req_q <= 1'b0;
    end else if (hold_reset || !HAS_CLK_REQ) begin
      clk_req_q <= 1'b0;
    end else if (state_q == ST_SLEEP &&
                 seq_cnt_q == CNT_W'(CLKREQ_CYC - 1)) begin
      clk_req_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Crystal oscillator enable
  // --------------------------------------------------------------------------
  // The synchroniser shows its reset value for two cycles after reset;
  // holding the enable until it has filled avoids a false crystal start
  logic [1:0] warm_q;
  logic       xtal_en_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warm_q <= 2'h0;
    end else begin
      warm_q <= {warm_q[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_en_q <= 1'b0;
    end else if (warm_q[1]) begin
      xtal_en_q <= ~tcxo_s;
    end
  end

  // --------------------------------------------------------------------------
  // Slow clock presence detector
  // --------------------------------------------------------------------------
  // Sampled at the end of sleep, when the external clock must be stable;
  // a slow clock faster than half of clk cannot be seen reliably.
  logic              slow_prev_q;
  logic [CNT_W-1:0]  wdg_cnt_q;
  logic              slow_missing_q;
  logic              use_internal_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_prev_q    <= 1'b0;
      wdg_cnt_q      <= '0;
      slow_missing_q <= 1'b1;
    end else begin
      slow_prev_q <= slow_s;
      if (slow_s != slow_prev_q) begin
        wdg_cnt_q      <= '0;
        slow_missing_q <= 1'b0;
      end else if (wdg_cnt_q == CNT_W'(SLOW_WDG_CYC - 1)) begin
        slow_missing_q <= 1'b1;
      end else begin
        wdg_cnt_q <= wdg_cnt_q + CNT_W'(1);
      end
    end
  end

  // Selection latched when sleep ends, held until the next reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      use_internal_q <= 1'b1;
    end else if (hold_reset) begin
      use_internal_q <= 1'b1;
    end else if (state_q == ST_SLEEP &&
                 seq_cnt_q == CNT_W'(SLEEP_CYC - 1)) begin
      use_internal_q <= slow_missing_q;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  logic glob_rst_n_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      glob_rst_n_q <= 1'b0;
    end else begin
      glob_rst_n_q <= ~hold_reset;
    end
  end

  assign global_reset_n           = glob_rst_n_q;
  assign clk_request              = clk_req_q;
  assign crystal_osc_en           = xtal_en_q;
  assign slow_oscillator_internal = use_internal_q;
  assign startup_go               = (state_q == ST_RUN);
  assign seq_state                = state_q;

endmodule

// ---- startup_seq_chk.sv ----
// Port checker for the startup and reset sequencer
module startup_seq_chk
  import startup_seq_pkg::*;
#(
  parameter int unsigned CLKREQ_CYC   = 5,
  parameter int unsigned SLEEP_CYC    = 40,
  parameter int unsigned SLOW_WDG_CYC = 8
) (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // Pins seen by the sequencer
  input wire logic                        core_supply_good,
  input wire logic                        ext_reset_n,
  input wire logic                        tcxo_present,
  input wire logic                        slow_clock_input,
  // Sequencer outputs
  input wire logic                        global_reset_n,
  input wire logic                        clk_request,
  input wire logic                        crystal_osc_en,
  input wire logic                        startup_go,
  input wire logic                        slow_oscillator_internal,
  input wire startup_seq_pkg::seq_state_t seq_state
);
  logic [23:0] slp_q;
  logic [23:0] idle_q;
  logic        prev_q;
  // Sleep length and slow clock idle time, counted here independently
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slp_q  <= '0;
      idle_q <= '0;
      prev_q <= 1'b0;
    end else begin
      slp_q  <= (seq_state == ST_SLEEP) ? slp_q + 24'h1 : '0;
      idle_q <= (slow_clock_input != prev_q) ? '0 : idle_q + 24'h1;
      prev_q <= slow_clock_input;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ext_hold_a: assert property (
    !ext_reset_n [*5] |-> !global_reset_n) else $error("ext hold");
  supply_hold_a: assert property (
    !core_supply_good [*5] |-> !global_reset_n) else $error("por hold");
  release_sleep_a: assert property (
    $rose(global_reset_n) |-> ##[0:1] seq_state == ST_SLEEP)
    else $error("no sleep after release");
  go_state_a: assert property (
    startup_go |-> global_reset_n && seq_state == ST_RUN)
    else $error("go while in reset");
  sleep_min_a: assert property (
    (seq_state == ST_RUN && slp_q != 0) |->
      (slp_q >= SLEEP_CYC && slp_q <= SLEEP_CYC + 2))
    else $error("sleep length");
  clkreq_dly_a: assert property (
    $rose(clk_request) |-> seq_state == ST_SLEEP &&
      slp_q + 1 >= CLKREQ_CYC && slp_q <= CLKREQ_CYC + 1)
    else $error("clock request delay");
  xtal_sel_a: assert property (
    $stable(tcxo_present) [*5] |-> crystal_osc_en == !tcxo_present)
    else $error("crystal enable");
  slow_int_a: assert property (
    ($rose(startup_go) && idle_q > SLOW_WDG_CYC + 4) |->
      ##[0:1] slow_oscillator_internal) else $error("slow internal");
  slow_ext_a: assert property (
    ($rose(startup_go) && idle_q < SLOW_WDG_CYC / 2) |->
      ##[0:1] !slow_oscillator_internal) else $error("slow external");
endmodule

bind startup_reset_sequencer startup_seq_chk #(.CLKREQ_CYC(CLKREQ_CYC),
  .SLEEP_CYC(SLEEP_CYC), .SLOW_WDG_CYC(SLOW_WDG_CYC)) u_chk (
  .clk(clk), .rst_n(rst_n), .core_supply_good(core_supply_good),
  .ext_reset_n(ext_reset_n), .tcxo_present(tcxo_present),
  .slow_clock_input(slow_clock_input), .global_reset_n(global_reset_n),
  .clk_request(clk_request), .crystal_osc_en(crystal_osc_en),
  .startup_go(startup_go), .seq_state(seq_state),
  .slow_oscillator_internal(slow_oscillator_internal));

// ---- osc_partner.sv ----
// Model of the slow oscillator feeding the sequencer
module osc_partner (
  input  wire logic clk,
  input  wire logic run,
  output logic      slow_clock_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0;
  logic       lvl_q = 1'b0;
  // A missing oscillator stands still, so the sequencer must notice
  always @(posedge clk) begin
    div_q <= div_q + 2'h1;
    if (run && div_q == 2'h3) lvl_q <= ~lvl_q;
  end
  assign slow_clock_input = lvl_q;
endmodule

// ---- startup_reset_sequencer_tb.sv ----
// Self-checking bench for the startup and reset sequencer
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module startup_reset_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import startup_seq_pkg::*;
  localparam int POR_T = 20;
  localparam int SLP_T = 40;
  logic clk = 1'b0, rst_n = 1'b0, supply = 1'b0, ext_n = 1'b1;
  logic tcxo = 1'b1, run = 1'b1, slow, g_n, req, req_none, xo, slow_oscillator, go;
  seq_state_t st;
  int err_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  osc_partner osc (.clk(clk), .run(run), .slow_clock_input(slow));
  startup_reset_sequencer #(.POR_CYC(POR_T), .CLKREQ_CYC(5),
    .SLEEP_CYC(SLP_T), .SLOW_WDG_CYC(8)) uut (.clk(clk), .rst_n(rst_n),
    .core_supply_good(supply), .ext_reset_n(ext_n), .tcxo_present(tcxo),
    .slow_clock_input(slow), .global_reset_n(g_n), .clk_request(req),
    .crystal_osc_en(xo), .slow_oscillator_internal(slow_oscillator), .startup_go(go),
    .seq_state(st));
  // Variant without the clock request output
  startup_reset_sequencer #(.HAS_CLK_REQ(1'b0), .POR_CYC(POR_T),
    .CLKREQ_CYC(5), .SLEEP_CYC(SLP_T), .SLOW_WDG_CYC(8)) uut_nreq (
    .clk(clk), .rst_n(rst_n), .core_supply_good(supply),
    .ext_reset_n(ext_n), .tcxo_present(tcxo), .slow_clock_input(slow),
    .global_reset_n(), .clk_request(req_none), .crystal_osc_en(),
    .slow_oscillator_internal(), .startup_go(), .seq_state());
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_go();
    int i = 0;
    while (go !== 1'b1 && i < 200) begin
      cyc(1);
      i++;
    end
    `CHK(go, 1'b1)
  endtask
  task automatic t_power_up();
    @(posedge clk) supply <= 1'b1;
    cyc(POR_T);
    `CHK(g_n, 1'b0)
    cyc(8);
    `CHK(g_n, 1'b1)
    `CHK(st, ST_SLEEP)
    cyc(SLP_T - 8);
    `CHK(go, 1'b0)
    wait_go();
    `CHK(req, 1'b1)
    `CHK(req_none, 1'b0)
    `CHK(xo, 1'b0)
    `CHK(slow_oscillator, 1'b0)
  endtask
  task automatic t_ext_reset();
    @(posedge clk) ext_n <= 1'b0;
    cyc(POR_T + 20);
    `CHK(g_n, 1'b0)
    `CHK(st, ST_RESET)
    `CHK(req, 1'b0)
    @(posedge clk) ext_n <= 1'b1;
    cyc(6);
    `CHK(g_n, 1'b1)
    wait_go();
  endtask
  task automatic t_no_osc();
    @(posedge clk) begin
      run <= 1'b0;
      tcxo <= 1'b0;
      ext_n <= 1'b0;
    end
    cyc(4);
    @(posedge clk) ext_n <= 1'b1;
    wait_go();
    `CHK(slow_oscillator, 1'b1)
    `CHK(xo, 1'b1)
  endtask
  task automatic t_supply_drop();
    @(posedge clk) begin
      run <= 1'b1;
      tcxo <= 1'b1;
      ext_n <= 1'b0;
    end
    cyc(4);
    @(posedge clk) ext_n <= 1'b1;
    cyc(12);
    @(posedge clk) supply <= 1'b0;
    cyc(6);
    `CHK(g_n, 1'b0)
    `CHK(go, 1'b0)
    @(posedge clk) supply <= 1'b1;
    wait_go();
    `CHK(slow_oscillator, 1'b0)
  endtask
  task automatic final_report();
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #25000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_power_up();
    t_ext_reset();
    t_no_osc();
    t_supply_drop();
    final_report();
  end
endmodule
